/* dv/adc_link_props.sv */
// Protocol checks on the serial register link between host and converter ends.
`timescale 1ns/1ns
`default_nettype none
module adc_link_props (
	input  wire logic aclk,            // System clock.
	input  wire logic aresetn,         // Synchronous reset, active low.
	input  wire logic serial_clk,      // Link clock.
	input  wire logic serial_select_n, // Frame select, active low.
	input  wire logic serial_in,       // Host to device data.
	input  wire logic serial_out,      // Device to host data.
	input  wire logic serial_out_en    // Device drives read data.
);
	// ----------------------------------------------------------------
	// Frame bit counter
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic       clk_q;
	logic [4:0] rise_q;
	wire        rise = serial_clk && !clk_q;

	// The count is cleared only by reset or a high select, so a short frame shows up at its end.
	always_ff @(posedge aclk) begin
		clk_q <= serial_clk;
		if (!aresetn || serial_select_n)
			rise_q <= 5'h00;
		else if (rise)
			rise_q <= rise_q + 5'h01;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	idle_clk_low_a: assert property (serial_select_n |-> !serial_clk)
		else $error("link clock high outside a frame");
	high_phase_a: assert property ($rose(serial_clk) |-> serial_clk[*6] ##1 !serial_clk)
		else $error("link clock high phase not six cycles");
	low_phase_a: assert property ($fell(serial_clk) |-> !serial_clk[*6])
		else $error("link clock low phase too short");
	in_stable_a: assert property (serial_clk |-> $stable(serial_in) && $stable(serial_select_n))
		else $error("host data or select moved while link clock high");
	frame_len_a: assert property ($rose(serial_select_n) |-> rise_q == 5'd24)
		else $error("frame did not carry 24 link clock edges");
	header_mid_a: assert property (rise && rise_q == 5'd1 |-> serial_in)
		else $error("second header bit not one");
	header_low_a: assert property (rise && rise_q == 5'd2 |-> !serial_in)
		else $error("third header bit not zero");
	out_release_a: assert property ($rose(serial_select_n) |-> ##6 !serial_out_en)
		else $error("device still drives data after frame end");
	en_start_a: assert property ($rose(serial_out_en) |-> !serial_select_n && rise_q >= 5'd3)
		else $error("device drove data before a read header");
	out_hold_a: assert property (serial_out_en && serial_clk && rise_q > 5'd8 |-> $stable(serial_out))
		else $error("read data moved while link clock high");
	out_idle_a: assert property (serial_select_n[*6] |-> !serial_out && !serial_out_en)
		else $error("device output active while idle");

	read_frame_c: cover property ($fell(serial_out_en));
	frame_end_c: cover property ($rose(serial_select_n));
	last_bit_c: cover property (rise && rise_q == 5'd23);
endmodule // adc_link_props
`default_nettype wire

/* dv/tb_top.sv */
// Bench joining the AXI4-Lite host to the converter registers over the serial link.
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import adc_cfg_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	logic        aclk = 1'h0, aresetn = 1'h0, cal_pin = 1'h0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  wstrb = 4'hf;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	mode_type    converter_mode;
	logic        mode_invalid, direct_coupling_select, pattern_output_select, clock_swallow;
	logic        aperture_delay_enable, cal_request, cal_start, termination_value_select;
	logic        resistor_trim_enable, coefficient_scan_enable;
	logic [1:0]  input_sel_a, input_sel_b, input_sel_c, input_sel_d;
	int          n_errors = 0, cmp_count = 0, n_swallow = 0, n_cal = 0, cycles = 0;

	adc_serial_if adc_serial_if_inst ();
	adc_serial_host adc_serial_host_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .link(adc_serial_if_inst));
	adc_config_regs adc_config_regs_inst (.aclk, .aresetn, .link(adc_serial_if_inst), .cal_pin,
		.converter_mode, .mode_invalid, .input_sel_a, .input_sel_b, .input_sel_c, .input_sel_d,
		.direct_coupling_select, .pattern_output_select, .clock_swallow, .aperture_delay_enable,
		.cal_request, .cal_start, .termination_value_select, .resistor_trim_enable,
		.coefficient_scan_enable);
	adc_link_props adc_link_props_inst (.aclk, .aresetn,
		.serial_clk(adc_serial_if_inst.serial_clk),
		.serial_select_n(adc_serial_if_inst.serial_select_n),
		.serial_in(adc_serial_if_inst.serial_in), .serial_out(adc_serial_if_inst.serial_out),
		.serial_out_en(adc_serial_if_inst.serial_out_en));

	always #5 aclk = ~aclk;

	// Pulses are counted as they happen, so scenarios only compare totals afterwards.
	always @(posedge aclk) begin
		cycles++;
		if (clock_swallow === 1'h1)
			n_swallow++;
		if (cal_start === 1'h1)
			n_cal++;
		if (cycles == 30000) begin
			n_errors++;
			end_of_test();
		end
	end

	// ----------------------------------------------------------------
	// Bus and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task end_of_test;
		$display("Compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Each handshake is judged on the values standing at the rising edge.
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do @(posedge aclk); while (!(awready && wready));
		awvalid <= 1'h0;
		wvalid <= 1'h0;
		do @(posedge aclk); while (!bvalid);
		r = bresp;
		bready <= 1'h0;
	endtask

	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'h0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask

	task automatic dev_op(input logic is_rd, input logic [4:0] a, input logic [15:0] d,
		output logic [15:0] q);
		logic [31:0] s;
		logic [1:0]  r;
		axi_wr(REG_COMMAND, {7'h00, is_rd, 3'h0, a, d}, r);
		chk("command_resp", RESP_OKAY, r);
		do axi_rd(REG_STATUS, s, r); while (s[STATUS_DONE_BIT] !== 1'h1);
		axi_rd(REG_READ_DATA, s, r);
		q = s[15:0];
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] q;
		dev_op(1'h0, a, d, q);
	endtask

	task automatic rd(input logic [4:0] a, output logic [15:0] q);
		dev_op(1'h1, a, 16'h0000, q);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_defaults;
		logic [15:0] q;
		rd(5'h01, q);
		chk("config_one", 16'h0000, q);
		rd(5'h02, q);
		chk("config_two", 16'h0530, q);
		rd(5'h03, q);
		chk("calibration_setup", 16'hf580, q);
		chk("coupling", 1'h0, direct_coupling_select);
		chk("termination", 1'h0, termination_value_select);
		chk("trim", 1'h1, resistor_trim_enable);
		chk("scan", 1'h0, coefficient_scan_enable);
	endtask

	task automatic t_modes;
		logic [15:0] d, q;
		logic [7:0]  sel_exp [4] = '{8'haa, 8'h99, 8'h9c, 8'h00};
		for (int m = 0; m < 4; m++) begin
			d = {m[1:0], 8'h36, m[0], 1'h1, m[1], 1'h1, 1'h0, m[0] ^ m[1]};
			wr(5'h01, d);
			rd(5'h01, q);
			chk("config_one", d & 16'hffeb, q);
			chk("mode", m, converter_mode);
			chk("mode_invalid", m == 3, mode_invalid);
			chk("selects", sel_exp[m], {input_sel_a, input_sel_b, input_sel_c, input_sel_d});
			chk("levels", {m[0], m[1], m[0] ^ m[1]}, {direct_coupling_select,
				pattern_output_select, aperture_delay_enable});
		end
	endtask

	task automatic t_swallow;
		int n0 = n_swallow;
		wr(5'h01, 16'h0002);
		chk("swallow", n0 + 1, n_swallow);
		wr(5'h01, 16'h0002);
		chk("swallow", n0 + 1, n_swallow);
		wr(5'h01, 16'h0000);
		wr(5'h01, 16'h0002);
		chk("swallow", n0 + 2, n_swallow);
	endtask

	task automatic t_cal;
		logic [15:0] q;
		int          n0 = n_cal;
		wr(5'h02, 16'h8000);
		chk("cal_start", n0 + 1, n_cal);
		rd(5'h02, q);
		chk("config_two", 16'h8530, q);
		cal_pin <= 1'h1;
		wr(5'h02, 16'hc000);
		chk("cal_start", n0 + 1, n_cal);
		chk("termination", 1'h1, termination_value_select);
		wr(5'h02, 16'h0000);
		chk("cal_request", 1'h1, cal_request);
		cal_pin <= 1'h0;
		repeat (6) @(posedge aclk);
		chk("cal_request", 1'h0, cal_request);
		cal_pin <= 1'h1;
		repeat (6) @(posedge aclk);
		chk("cal_start", n0 + 2, n_cal);
		cal_pin <= 1'h0;
	endtask

	task automatic t_cal_setup;
		logic [15:0] q;
		wr(5'h03, 16'h0020);
		rd(5'h03, q);
		chk("calibration_setup", 16'he020, q);
		chk("trim_scan", 2'h1, {resistor_trim_enable, coefficient_scan_enable});
		wr(5'h03, 16'h101f);
		rd(5'h03, q);
		chk("calibration_setup", 16'hf000, q);
		chk("trim_scan", 2'h2, {resistor_trim_enable, coefficient_scan_enable});
	endtask

	task automatic t_refused;
		logic [31:0] s;
		logic [1:0]  r;
		logic [15:0] q;
		axi_rd(12'h00c, s, r);
		chk("unmapped_resp", 2'h2, r);
		axi_rd(REG_COMMAND, s, r);
		chk("command_read", 32'h0, s);
		axi_wr(12'h00c, 32'h0, r);
		chk("write_resp", RESP_SLVERR, r);
		wstrb <= 4'h3;
		wr(5'h01, 16'h0020);
		wstrb <= 4'hf;
		rd(5'h01, q);
		chk("strobe_refused", 16'h0002, q);
		rd(5'h04, q);
		chk("other_reg", 16'h0000, q);
	endtask

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_defaults();
		t_modes();
		t_swallow();
		t_cal();
		t_cal_setup();
		t_refused();
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire

/* src/adc_cfg_pkg.sv */
// Constants and types shared by both ends of the converter register link.
package adc_cfg_pkg;

	// ----------------------------------------------------------------
	// Serial frame
	// ----------------------------------------------------------------
	localparam int         FRAME_BITS    = 24;
	localparam int         HEADER_BITS   = 8;
	localparam logic [4:0] LAST_BIT_IDX  = 5'd23;
	localparam logic [4:0] HEADER_IDX    = 5'd7;
	localparam logic [4:0] FIRST_DATA    = 5'd8;
	localparam logic [2:0] HDR_WRITE     = 3'h2;
	localparam logic [2:0] HDR_READ      = 3'h6;

	// ----------------------------------------------------------------
	// Device register map
	// ----------------------------------------------------------------
	localparam logic [4:0]  ADDR_CONFIG_ONE     = 5'h01;
	localparam logic [4:0]  ADDR_CONFIG_TWO     = 5'h02;
	localparam logic [4:0]  ADDR_CAL_SETUP      = 5'h03;
	localparam logic [15:0] CONFIG_ONE_RESET    = 16'h0000;
	localparam logic [15:0] CONFIG_TWO_RESET    = 16'h0530;
	localparam logic [15:0] CAL_SETUP_RESET     = 16'hf580;

	localparam int MODE_LSB      = 14;
	localparam int SEL_A_LSB     = 6;
	localparam int SEL_B_LSB     = 8;
	localparam int SEL_C_LSB     = 10;
	localparam int SEL_D_LSB     = 12;
	localparam int COUPLING_BIT  = 5;
	localparam int PATTERN_BIT   = 3;
	localparam int SWALLOW_BIT   = 1;
	localparam int APERTURE_BIT  = 0;
	localparam int CAL_BIT       = 15;
	localparam int TERM_BIT      = 14;
	localparam int TRIM_BIT      = 12;
	localparam int SCAN_BIT      = 5;

	// Reserved fields: mask selects the bits, value is what must be written.
	localparam logic [15:0] CONFIG_ONE_RES_MASK = 16'h0014;
	localparam logic [15:0] CONFIG_ONE_RES_VAL  = 16'h0000;
	localparam logic [15:0] CONFIG_TWO_RES_MASK = 16'h3fff;
	localparam logic [15:0] CONFIG_TWO_RES_VAL  = 16'h0530;
	localparam logic [15:0] CAL_RES_MASK        = 16'he01f;
	localparam logic [15:0] CAL_RES_VAL         = 16'he000;

	typedef enum logic [1:0] {MODE_SINGLE, MODE_DUAL, MODE_QUAD, MODE_INVALID} mode_type;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS     = 10;
	localparam int SERIAL_PERIOD_NS  = 125;
	localparam int SCLK_HALF_CYCLES  = SERIAL_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam logic [3:0] SCLK_HALF = 4'(SCLK_HALF_CYCLES - 1);

	// ----------------------------------------------------------------
	// Controller registers on AXI4-Lite
	// ----------------------------------------------------------------
	localparam int          AXI_ADDR_W      = 12;
	localparam logic [11:0] REG_COMMAND     = 12'h000;
	localparam logic [11:0] REG_STATUS      = 12'h004;
	localparam logic [11:0] REG_READ_DATA   = 12'h008;
	localparam int          CMD_ADDR_LSB    = 16;
	localparam int          CMD_READ_BIT    = 24;
	localparam int          STATUS_BUSY_BIT = 0;
	localparam int          STATUS_DONE_BIT = 1;
	localparam logic [1:0]  RESP_OKAY       = 2'b00;
	localparam logic [1:0]  RESP_SLVERR     = 2'b10;

endpackage

/* src/adc_config_regs.sv */
// Converter end: serial register port and configuration/calibration registers.
//
// Behaviour
// - Mode bits select single, dual, quad; 11 invalid.
// - Single mode: bits 7:6 feed every converter.
// - Dual: 7:6 to A/C, 9:8 to B/D.
// - Quad: A 7:6, B 9:8, C 11:10, D 13:12.
// - Coupling bit: zero AC, one DC.
// - Host writes zero to config bits 4, 2.
// - Pattern bit substitutes test pattern for samples.
// - Swallow bit drops one clock; clear before reuse.
// - Aperture bit enables delay adjustment from register.
// - Calibration bit starts calibration; never self-clears.
// - Trigger is bit OR pin; both low rearm.
// - Termination bit: zero 100 ohms, one 150.
// - Host writes 0x0530 into config-two reserved bits.
// - Host keeps calibration top bits at 111.
// - Trim bit lets calibration trim terminations.
// - Scan bit enables coefficient vector access.
// - Host writes zeros to calibration low bits.
// - 24-bit MSB-first frame: header, address, data.
// - Select low whole frame; sample on rise.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module adc_config_regs
	import adc_cfg_pkg::*;
(
	input  wire logic            aclk,                 // System clock.
	input  wire logic            aresetn,              // Synchronous reset, active low.
	adc_serial_if.device_end     link,                 // Serial register port.
	input  wire logic            cal_pin,              // External calibration pin, asynchronous.
	output mode_type             converter_mode,       // Sampling mode.
	output logic                 mode_invalid,         // Mode field holds the unusable code.
	output logic [1:0]           input_sel_a,          // Input routed to converter A.
	output logic [1:0]           input_sel_b,          // Input routed to converter B.
	output logic [1:0]           input_sel_c,          // Input routed to converter C.
	output logic [1:0]           input_sel_d,          // Input routed to converter D.
	output logic                 direct_coupling_select, // High selects DC coupling.
	output logic                 pattern_output_select,  // High substitutes the test pattern.
	output logic                 clock_swallow,        // One-cycle pulse: drop one clock.
	output logic                 aperture_delay_enable, // Aperture delay adjustment on.
	output logic                 cal_request,          // Level: bit OR pin.
	output logic                 cal_start,            // One-cycle pulse: start calibration.
	output logic                 termination_value_select, // High selects 150 ohm.
	output logic                 resistor_trim_enable, // Calibration trims terminations.
	output logic                 coefficient_scan_enable // Coefficient scan access allowed.
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        sclk_s1;
		logic        sclk_s2;
		logic        sclk_s3;
		logic        sel_s1;
		logic        sel_s2;
		logic        sdi_s1;
		logic        sdi_s2;
		logic        cal_s1;
		logic        cal_s2;
		logic [4:0]  bit_count;
		logic [23:0] shift_in;
		logic [15:0] shift_out;
		logic        reading;
		logic [15:0] config_one;
		logic [15:0] config_two;
		logic [15:0] cal_setup;
		logic        swallow_prev;
		logic        swallow_pulse;
		logic        cal_prev;
		logic        cal_pulse;
		logic [7:0]  routes;
	} dev_state_type;

	dev_state_type state_q;
	dev_state_type state_d;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic [15:0] read_reg(input logic [4:0] addr,
		input logic [15:0] one, input logic [15:0] two, input logic [15:0] cal);
		logic [15:0] value;
		value = 16'h0000;
		unique case (addr)
			ADDR_CONFIG_ONE: value = one;
			ADDR_CONFIG_TWO: value = two;
			ADDR_CAL_SETUP:  value = cal;
			default:         value = 16'h0000;
		endcase
		return value;
	endfunction

	// Packs the A, B, C, D selects (A in the low pair) from the first register.
	function automatic logic [7:0] route_inputs(input logic [15:0] cfg);
		logic [1:0] a;
		logic [1:0] b;
		logic [1:0] c;
		logic [1:0] d;
		logic [7:0] r;
		a = cfg[SEL_A_LSB +: 2];
		b = cfg[SEL_B_LSB +: 2];
		c = cfg[SEL_C_LSB +: 2];
		d = cfg[SEL_D_LSB +: 2];
		unique case (mode_type'(cfg[MODE_LSB +: 2]))
			MODE_SINGLE:  r = {a, a, a, a};
			MODE_DUAL:    r = {b, a, b, a};
			MODE_QUAD:    r = {d, c, b, a};
			MODE_INVALID: r = 8'h00;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic        sclk_rise;
	logic        sclk_fall;
	logic [23:0] next_shift;
	logic        cal_level;

	always_comb begin
		state_d = state_q;
		state_d.sclk_s1 = link.serial_clk;
		state_d.sclk_s2 = state_q.sclk_s1;
		state_d.sclk_s3 = state_q.sclk_s2;
		state_d.sel_s1  = link.serial_select_n;
		state_d.sel_s2  = state_q.sel_s1;
		state_d.sdi_s1  = link.serial_in;
		state_d.sdi_s2  = state_q.sdi_s1;
		state_d.cal_s1  = cal_pin;
		state_d.cal_s2  = state_q.cal_s1;

		sclk_rise  = state_q.sclk_s2 & ~state_q.sclk_s3;
		sclk_fall  = ~state_q.sclk_s2 & state_q.sclk_s3;
		next_shift = {state_q.shift_in[22:0], state_q.sdi_s2};

		if (state_q.sel_s2) begin
			// A frame cut short by select rising is dropped whole.
			state_d.bit_count = 5'd0;
			state_d.reading   = 1'b0;
		end else if (sclk_rise && state_q.bit_count <= LAST_BIT_IDX) begin
			state_d.shift_in  = next_shift;
			state_d.bit_count = state_q.bit_count + 5'd1;
			if (state_q.bit_count == HEADER_IDX && next_shift[7:5] == HDR_READ) begin
				state_d.reading   = 1'b1;
				state_d.shift_out = read_reg(next_shift[4:0], state_q.config_one,
					state_q.config_two, state_q.cal_setup);
			end
			if (state_q.bit_count == LAST_BIT_IDX && next_shift[23:21] == HDR_WRITE) begin
				unique case (next_shift[20:16])
					ADDR_CONFIG_ONE: state_d.config_one = next_shift[15:0];
					ADDR_CONFIG_TWO: state_d.config_two = next_shift[15:0];
					ADDR_CAL_SETUP:  state_d.cal_setup  = next_shift[15:0];
					default:         state_d.shift_in   = next_shift;
				endcase
			end
		end else if (sclk_fall && state_q.reading && state_q.bit_count > FIRST_DATA) begin
			state_d.shift_out = {state_q.shift_out[14:0], 1'b0};
		end

		// A bump is requested only by a fresh 0-to-1 of the bit.
		state_d.swallow_prev  = state_q.config_one[SWALLOW_BIT];
		state_d.swallow_pulse = state_q.config_one[SWALLOW_BIT] & ~state_q.swallow_prev;

		// Holding either source high blocks a new start from the other.
		cal_level           = state_q.config_two[CAL_BIT] | state_q.cal_s2;
		state_d.cal_prev    = cal_level;
		state_d.cal_pulse   = cal_level & ~state_q.cal_prev;

		state_d.routes = route_inputs(state_q.config_one);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q            <= '0;
			state_q.sclk_s1    <= 1'b0;
			state_q.sel_s1     <= 1'b1;
			state_q.sel_s2     <= 1'b1;
			state_q.config_one <= CONFIG_ONE_RESET;
			state_q.config_two <= CONFIG_TWO_RESET;
			state_q.cal_setup  <= CAL_SETUP_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign link.serial_out    = state_q.shift_out[15];
	assign link.serial_out_en = state_q.reading & ~state_q.sel_s2;

	assign converter_mode           = mode_type'(state_q.config_one[MODE_LSB +: 2]);
	assign mode_invalid             = (converter_mode == MODE_INVALID);
	assign input_sel_a              = state_q.routes[1:0];
	assign input_sel_b              = state_q.routes[3:2];
	assign input_sel_c              = state_q.routes[5:4];
	assign input_sel_d              = state_q.routes[7:6];
	assign direct_coupling_select   = state_q.config_one[COUPLING_BIT];
	assign pattern_output_select    = state_q.config_one[PATTERN_BIT];
	assign clock_swallow            = state_q.swallow_pulse;
	assign aperture_delay_enable    = state_q.config_one[APERTURE_BIT];
	assign cal_request              = state_q.cal_prev;
	assign cal_start                = state_q.cal_pulse;
	assign termination_value_select = state_q.config_two[TERM_BIT];
	assign resistor_trim_enable     = state_q.cal_setup[TRIM_BIT];
	assign coefficient_scan_enable  = state_q.cal_setup[SCAN_BIT];

endmodule // adc_config_regs
`default_nettype wire

/* src/adc_serial_host.sv */
// Host end: AXI4-Lite command registers driving the serial register port.
`timescale 1ns/1ns
`default_nettype none
module adc_serial_host
	import adc_cfg_pkg::*;
(
	input  wire logic                  aclk,     // System clock.
	input  wire logic                  aresetn,  // Synchronous reset, active low.
	input  wire logic [AXI_ADDR_W-1:0] awaddr,   // Write address.
	input  wire logic                  awvalid,  // Write address valid.
	output logic                       awready,  // Write address ready.
	input  wire logic [31:0]           wdata,    // Write data.
	input  wire logic [3:0]            wstrb,    // Write byte strobes.
	input  wire logic                  wvalid,   // Write data valid.
	output logic                       wready,   // Write data ready.
	output logic [1:0]                 bresp,    // Write response.
	output logic                       bvalid,   // Write response valid.
	input  wire logic                  bready,   // Write response ready.
	input  wire logic [AXI_ADDR_W-1:0] araddr,   // Read address.
	input  wire logic                  arvalid,  // Read address valid.
	output logic                       arready,  // Read address ready.
	output logic [31:0]                rdata,    // Read data.
	output logic [1:0]                 rresp,    // Read response.
	output logic                       rvalid,   // Read data valid.
	input  wire logic                  rready,   // Read data ready.
	adc_serial_if.host_end             link      // Serial register port.
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {IDLE, LOW, HIGH, FINISH} phase_type;

	typedef struct packed {
		phase_type   phase;
		logic [3:0]  div;
		logic [4:0]  bit_idx;
		logic [23:0] shift;
		logic [15:0] capture;
		logic [15:0] read_data;
		logic        done;
		logic        sclk;
		logic        sel_n;
		logic        sdo_s1;
		logic        sdo_s2;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} host_state_type;

	host_state_type state_q;
	host_state_type state_d;

	// Forces reserved fields to their mandatory values.
	function automatic logic [15:0] fix_reserved(input logic [4:0] addr, input logic [15:0] v);
		logic [15:0] r;
		r = v;
		unique case (addr)
			ADDR_CONFIG_ONE: r = (v & ~CONFIG_ONE_RES_MASK) | CONFIG_ONE_RES_VAL;
			ADDR_CONFIG_TWO: r = (v & ~CONFIG_TWO_RES_MASK) | CONFIG_TWO_RES_VAL;
			ADDR_CAL_SETUP:  r = (v & ~CAL_RES_MASK) | CAL_RES_VAL;
			default:         r = v;
		endcase
		return r;
	endfunction

	logic        write_take;
	logic        busy;
	logic [4:0]  cmd_addr;

	assign busy       = (state_q.phase != IDLE);
	assign write_take = awvalid & wvalid & ~state_q.bvalid;
	assign awready    = write_take;
	assign wready     = write_take;
	assign arready    = ~state_q.rvalid;
	assign cmd_addr   = wdata[CMD_ADDR_LSB +: 5];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d        = state_q;
		state_d.sdo_s1 = link.serial_out;
		state_d.sdo_s2 = state_q.sdo_s1;

		if (state_q.bvalid && bready) begin
			state_d.bvalid = 1'b0;
		end
		if (write_take) begin
			state_d.bvalid = 1'b1;
			state_d.bresp  = (awaddr == REG_COMMAND) ? RESP_OKAY : RESP_SLVERR;
			// Commands arriving while a frame runs are dropped, not queued.
			if (awaddr == REG_COMMAND && wstrb == 4'hf && !busy) begin
				state_d.shift = wdata[CMD_READ_BIT] ?
					{HDR_READ, cmd_addr, 16'h0000} :
					{HDR_WRITE, cmd_addr, fix_reserved(cmd_addr, wdata[15:0])};
				state_d.sel_n   = 1'b0;
				state_d.phase   = LOW;
				state_d.div     = 4'd0;
				state_d.bit_idx = 5'd0;
				state_d.done    = 1'b0;
			end
		end

		if (state_q.rvalid && rready) begin
			state_d.rvalid = 1'b0;
		end
		if (arvalid && !state_q.rvalid) begin
			state_d.rvalid = 1'b1;
			state_d.rresp  = RESP_OKAY;
			unique case (araddr)
				REG_STATUS:    state_d.rdata = {30'h0, state_q.done, busy};
				REG_READ_DATA: state_d.rdata = {16'h0000, state_q.read_data};
				REG_COMMAND:   state_d.rdata = 32'h0000_0000;
				default: begin
					state_d.rdata = 32'h0000_0000;
					state_d.rresp = RESP_SLVERR;
				end
			endcase
		end

		if (busy) begin
			state_d.div = state_q.div + 4'd1;
		end
		if (busy && state_q.div == SCLK_HALF) begin
			state_d.div = 4'd0;
			unique case (state_q.phase)
				LOW: begin
					state_d.sclk  = 1'b1;
					state_d.phase = HIGH;
				end
				HIGH: begin
					// Sampling late in the high phase covers the device's sync delay.
					state_d.capture = {state_q.capture[14:0], state_q.sdo_s2};
					state_d.sclk    = 1'b0;
					state_d.bit_idx = state_q.bit_idx + 5'd1;
					state_d.shift   = {state_q.shift[22:0], 1'b0};
					state_d.phase   = (state_q.bit_idx == LAST_BIT_IDX) ? FINISH : LOW;
				end
				FINISH: begin
					state_d.sel_n     = 1'b1;
					state_d.phase     = IDLE;
					state_d.done      = 1'b1;
					state_d.read_data = state_q.capture;
				end
				IDLE: state_d.div = 4'd0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q       <= '0;
			state_q.phase <= IDLE;
			state_q.sel_n <= 1'b1;
		end else begin
			state_q <= state_d;
		end
	end

	assign link.serial_clk      = state_q.sclk;
	assign link.serial_select_n = state_q.sel_n;
	assign link.serial_in       = state_q.shift[23];
	assign bvalid               = state_q.bvalid;
	assign bresp                = state_q.bresp;
	assign rvalid               = state_q.rvalid;
	assign rresp                = state_q.rresp;
	assign rdata                = state_q.rdata;

endmodule // adc_serial_host
`default_nettype wire

/* src/adc_serial_if.sv */
// Serial register link between the host controller and the converter.
`timescale 1ns/1ns
`default_nettype none
interface adc_serial_if;
	logic serial_clk;
	logic serial_select_n;
	logic serial_in;
	logic serial_out;
	logic serial_out_en;

	modport device_end (
		input  serial_clk,
		input  serial_select_n,
		input  serial_in,
		output serial_out,
		output serial_out_en
	);

	modport host_end (
		output serial_clk,
		output serial_select_n,
		output serial_in,
		input  serial_out,
		input  serial_out_en
	);
endinterface
`default_nettype wire
